//--- aic_ctrl.sv
/*
 * analog control decoder: program counter, analog field decode,
 * conversion register with successive approximation, conditional gating
 * of the alu, and a queue of finished conversion results.
 * assumes the fetch unit shows the fields of the word at o_pc in the same
 * cycle, and the analog front end answers i_cmp_high combinationally.
 */
`timescale 1ns/1ps
module aic_ctrl (
   input  wire logic                         i_mclk,
   input  wire logic                         i_rst,
   // fields of the current instruction
   input  wire logic [aic_pkg::ACODE_W-1:0]  i_acode,
   input  wire logic [aic_pkg::OPCODE_W-1:0] i_opcode,
   input  wire logic [aic_pkg::SHIFT_W-1:0]  i_shift,
   input  wire logic [aic_pkg::OPER_W-1:0]   i_dst,
   input  wire logic [aic_pkg::OPER_W-1:0]   i_src,
   // alu writing the conversion register as a destination
   input  wire logic                         i_conv_wr,
   input  wire logic [aic_pkg::CONV_W-1:0]   i_conv_data,
   // comparator: held input sample above converter output
   input  wire logic                         i_cmp_high,
   // program counter
   output logic      [aic_pkg::PC_W-1:0]     o_pc,
   // analog channel controls
   output logic                              o_in_sample,
   output logic      [aic_pkg::INCH_W-1:0]   o_in_chan,
   output logic                              o_out_drive,
   output logic      [aic_pkg::OUTCH_W-1:0]  o_out_chan,
   output logic      [aic_pkg::CONV_W-1:0]   o_dac,
   // alu controls
   output logic                              o_alu_enable,
   output logic                              o_cond_bit,
   output logic                              o_cond_active,
   output logic                              o_alu_nop,
   output logic                              o_clear_carry,
   // conversion register seen as a data word
   output logic      [aic_pkg::WORD_W-1:0]   o_conv_word,
   // finished conversion results
   output logic                              o_res_valid,
   input  wire logic                         i_res_ready,
   output logic      [aic_pkg::FIFO_W-1:0]   o_res_data,
   output logic                              o_res_room
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [aic_pkg::CONV_W-1:0]  conversion_register; // approximation register
   logic [aic_pkg::CONV_W-1:0]  next_conversion_register;
   logic [aic_pkg::CONV_W-1:0]  bit_mask;            // one-hot selected bit
   logic [aic_pkg::SEL_W-1:0]   bit_sel;             // selected bit index
   logic [aic_pkg::ACODE_W-1:0] code_off;            // offset within a group
   aic_pkg::aic_func_t          func;                // decoded function class
   aic_pkg::aic_state_t         state;               // sequencer state
   logic [1:0]                  drain;               // words left before wrap
   logic                        step_keep;           // outcome of a step
   logic                        is_sign_step;
   logic                        res_push;            // finished conversion

   // ------------------------------------------------------------------
   // analog field decode
   // ------------------------------------------------------------------
   // own decode path
   // kept apart from the alu so the analog action never costs a cycle
   always_comb begin
      func     = aic_pkg::AIC_F_NOP;
      code_off = '0;
      if (i_acode == aic_pkg::AC_EOP) begin
         func = aic_pkg::AIC_F_EOP;
      end else if (i_acode >= aic_pkg::AC_IN_BASE &&
                   i_acode <  aic_pkg::AC_IN_BASE + aic_pkg::AC_IN_N) begin
         func     = aic_pkg::AIC_F_IN;
         code_off = i_acode - aic_pkg::AC_IN_BASE;
      end else if (i_acode >= aic_pkg::AC_OUT_BASE &&
                   i_acode <  aic_pkg::AC_OUT_BASE + aic_pkg::AC_OUT_N) begin
         func     = aic_pkg::AIC_F_OUT;
         code_off = i_acode - aic_pkg::AC_OUT_BASE;
      end else if (i_acode >= aic_pkg::AC_CVT_BASE &&
                   i_acode <  aic_pkg::AC_CVT_BASE + aic_pkg::AC_BIT_N) begin
         func     = aic_pkg::AIC_F_CVT;
         code_off = i_acode - aic_pkg::AC_CVT_BASE;
      end else if (i_acode >= aic_pkg::AC_CND_BASE &&
                   i_acode <  aic_pkg::AC_CND_BASE + aic_pkg::AC_BIT_N) begin
         func     = aic_pkg::AIC_F_CND;
         code_off = i_acode - aic_pkg::AC_CND_BASE;
      end
      // unknown codes fall back to no analog action
   end

   // same bit numbering for steps and tests
   assign bit_sel      = code_off[aic_pkg::SEL_W-1:0];
   assign is_sign_step = (bit_sel == aic_pkg::SEL_SIGN);

   // ------------------------------------------------------------------
   // bit mask, one flop-free decode per bit
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < aic_pkg::CONV_W; gi++) begin : g_mask
         assign bit_mask[gi] = (bit_sel == (aic_pkg::SEL_W)'(gi));
      end
   endgenerate

   // ------------------------------------------------------------------
   // channel controls
   // ------------------------------------------------------------------
   // sample selected input
   assign o_in_sample = (func == aic_pkg::AIC_F_IN);
   assign o_in_chan   = code_off[aic_pkg::INCH_W-1:0];
   assign o_out_drive = (func == aic_pkg::AIC_F_OUT);
   assign o_out_chan  = code_off[aic_pkg::OUTCH_W-1:0];

   // ------------------------------------------------------------------
   // converter drive
   // ------------------------------------------------------------------
   // register feeds the converter
   // during a magnitude step the trial bit is shown so the comparator
   // answers for the register with that bit set
   always_comb begin
      o_dac = conversion_register;
      if (func == aic_pkg::AIC_F_CVT && !is_sign_step) begin
         o_dac = conversion_register | bit_mask;
      end
   end

   // ------------------------------------------------------------------
   // step outcome
   // ------------------------------------------------------------------
   // keep or clear by comparison
   // sign: register is zero, so the sign is set unless the input lies above;
   // magnitude: the bit stays when the input is still above the trial
   assign step_keep = is_sign_step ? !i_cmp_high : i_cmp_high;

   always_comb begin
      next_conversion_register = conversion_register;
      if (func == aic_pkg::AIC_F_CVT) begin
         if (step_keep) begin
            next_conversion_register = conversion_register | bit_mask;
         end else begin
            next_conversion_register = conversion_register & ~bit_mask;
         end
      end else if (i_conv_wr) begin
         // alu load; the program zeroes it here before a sequence
         next_conversion_register = i_conv_data;
      end
   end

   // ------------------------------------------------------------------
   // conversion register
   // ------------------------------------------------------------------
   // result left after the last step
   // a step wins over an alu write; the program must not mix the two
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         conversion_register <= aic_pkg::CONV_RESET;
      end else begin
         conversion_register <= next_conversion_register;
      end
   end

   // nine bits on top, ones below
   assign o_conv_word = {conversion_register, aic_pkg::LOW_FILL};

   // ------------------------------------------------------------------
   // conditional alu gating
   // ------------------------------------------------------------------
   // tested bit steers the operation
   assign o_cond_active = (func == aic_pkg::AIC_F_CND);
   assign o_cond_bit    = |(conversion_register & bit_mask);

   always_comb begin
      o_alu_enable = 1'b1;
      // cancel load or add on zero
      // the cycle still passes; subtract takes the bit through o_cond_bit
      if (o_cond_active && !o_cond_bit &&
          (i_opcode == aic_pkg::OP_LOAD || i_opcode == aic_pkg::OP_ADD)) begin
         o_alu_enable = 1'b0;
      end
   end

   assign o_alu_nop = (i_opcode == aic_pkg::OP_LOAD) &&
                      (i_dst == aic_pkg::OPER_ZERO_DST) &&
                      (i_src == aic_pkg::OPER_ZERO_CONST) &&
                      (i_shift == aic_pkg::SH_UNITY);
   assign o_clear_carry = o_alu_nop;

   // ------------------------------------------------------------------
   // program sequencer
   // ------------------------------------------------------------------
   // endless loop at one word per clock
   // wrap after last word or end code
   // the end code waits for the three words already in the pipeline
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= aic_pkg::AIC_S_RUN;
         drain <= '0;
         o_pc  <= aic_pkg::PC_FIRST;
      end else begin
         unique case (state)
            aic_pkg::AIC_S_RUN: begin
               if (func == aic_pkg::AIC_F_EOP) begin
                  state <= aic_pkg::AIC_S_DRAIN;
                  drain <= aic_pkg::EOP_LAG;
               end
               o_pc <= (o_pc == aic_pkg::PC_LAST) ? aic_pkg::PC_FIRST
                                                  : o_pc + 1'b1;
            end
            aic_pkg::AIC_S_DRAIN: begin
               if (drain == 2'h1) begin
                  // last fetched word done: restart the pass
                  state <= aic_pkg::AIC_S_RUN;
                  drain <= '0;
                  o_pc  <= aic_pkg::PC_FIRST;
               end else begin
                  drain <= drain - 1'b1;
                  o_pc  <= (o_pc == aic_pkg::PC_LAST) ? aic_pkg::PC_FIRST
                                                     : o_pc + 1'b1;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // result queue
   // ------------------------------------------------------------------
   // a finished value is offered the cycle after the lsb step; the loop
   // cannot stall, so a full queue drops it and o_res_room warns first
   logic res_pending;
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         res_pending <= 1'b0;
      end else begin
         res_pending <= (func == aic_pkg::AIC_F_CVT) &&
                        (bit_sel == aic_pkg::SEL_LSB);
      end
   end
   assign res_push = res_pending;

   aic_fifo #(
      .WIDTH (aic_pkg::FIFO_W),
      .DEPTH (aic_pkg::FIFO_D)
   ) i_aic_fifo (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_in_valid  (res_push),
      .o_in_ready  (o_res_room),
      .i_in_data   (conversion_register),
      .o_out_valid (o_res_valid),
      .i_out_ready (i_res_ready),
      .o_out_data  (o_res_data)
   );

endmodule : aic_ctrl

//--- aic_pkg.sv
/*
 * constants, codes and types shared by the analog control decoder and its
 * result queue.
 * assumes one instruction clock and an external fetch unit that presents
 * the fields of the word addressed by the program counter.
 */
package aic_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int CONV_W   = 9;    // conversion register width
   localparam int WORD_W   = 25;   // arithmetic data word width
   localparam int LOW_W    = 16;   // word bits below the conversion register
   localparam int PC_W     = 8;    // program counter width
   localparam int ACODE_W  = 6;    // analog control field width
   localparam int OPCODE_W = 3;    // alu opcode field width
   localparam int SHIFT_W  = 4;    // scaler field width
   localparam int OPER_W   = 6;    // operand address width
   localparam int INCH_W   = 2;    // input channel select width
   localparam int OUTCH_W  = 3;    // output channel select width
   localparam int SEL_W    = 4;    // bit select width (8 = sign)
   localparam int FIFO_W   = 9;    // result queue word width
   localparam int FIFO_D   = 4;    // result queue depth

   // ------------------------------------------------------------------
   // program counter limits and end-code latency
   // ------------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_FIRST = 8'h00;
   localparam logic [PC_W-1:0] PC_LAST  = 8'hBF;   // word 191
   localparam logic [1:0]      EOP_LAG  = 2'h3;    // words already fetched

   // ------------------------------------------------------------------
   // analog control codes
   // ------------------------------------------------------------------
   localparam logic [ACODE_W-1:0] AC_NOP      = 6'h00;
   localparam logic [ACODE_W-1:0] AC_EOP      = 6'h01; // end_of_program_code
   localparam logic [ACODE_W-1:0] AC_IN_BASE  = 6'h04; // sample_input_code 0..3
   localparam logic [ACODE_W-1:0] AC_OUT_BASE = 6'h08; // drive_output_code 0..7
   localparam logic [ACODE_W-1:0] AC_CVT_BASE = 6'h10; // lsb_convert_step..sign
   localparam logic [ACODE_W-1:0] AC_CND_BASE = 6'h20; // conditional_code 0..sign
   localparam logic [ACODE_W-1:0] AC_IN_N     = 6'h04;
   localparam logic [ACODE_W-1:0] AC_OUT_N    = 6'h08;
   localparam logic [ACODE_W-1:0] AC_BIT_N    = 6'h09;
   localparam logic [SEL_W-1:0]   SEL_SIGN    = 4'h8;  // index of the sign bit
   localparam logic [SEL_W-1:0]   SEL_MSB     = 4'h7;  // msb_convert_step
   localparam logic [SEL_W-1:0]   SEL_LSB     = 4'h0;  // lsb_convert_step

   // ------------------------------------------------------------------
   // alu fields that the decoder must recognise
   // ------------------------------------------------------------------
   localparam logic [OPCODE_W-1:0] OP_ADD  = 3'h0;
   localparam logic [OPCODE_W-1:0] OP_SUB  = 3'h1;
   localparam logic [OPCODE_W-1:0] OP_LOAD = 3'h2;     // load_operation
   localparam logic [SHIFT_W-1:0]  SH_UNITY = 4'hF;    // unity_shift
   localparam logic [OPER_W-1:0]   OPER_ZERO_DST = 6'h00;
   localparam logic [OPER_W-1:0]   OPER_ZERO_CONST = 6'h00; // zero_constant

   // ------------------------------------------------------------------
   // reset values and fill
   // ------------------------------------------------------------------
   localparam logic [CONV_W-1:0] CONV_RESET = 9'h000;
   localparam logic [LOW_W-1:0]  LOW_FILL   = 16'hFFFF;

   // analog function classes
   typedef enum logic [5:0] {
      AIC_F_NOP = 6'b000001,
      AIC_F_IN  = 6'b000010,
      AIC_F_OUT = 6'b000100,
      AIC_F_CVT = 6'b001000,
      AIC_F_CND = 6'b010000,
      AIC_F_EOP = 6'b100000
   } aic_func_t;

   // sequencer states
   typedef enum logic [1:0] {
      AIC_S_RUN   = 2'b01,
      AIC_S_DRAIN = 2'b10
   } aic_state_t;

endpackage : aic_pkg

//--- aic_fifo.sv
/*
 * small result queue with valid/ready on both sides.
 * assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module aic_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   // ------------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];        // entries
   logic [AW-1:0]    wr_ptr;             // next write slot
   logic [AW-1:0]    rd_ptr;             // oldest entry
   logic [AW:0]      count;              // occupancy
   logic             push;
   logic             pop;

   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[rd_ptr];

   // entries hold their value until overwritten after a pop
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   // pointers wrap; depth is a power of two
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : aic_fifo

//--- aic_ctrl_props.sv
/*
 * port checker for the analog control decoder, bound to aic_ctrl.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module aic_ctrl_chk (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic [5:0]  i_acode,
   input wire logic [2:0]  i_opcode,
   input wire logic [3:0]  i_shift,
   input wire logic [5:0]  i_dst,
   input wire logic [5:0]  i_src,
   input wire logic        i_cmp_high,
   input wire logic [7:0]  o_pc,
   input wire logic        o_in_sample,
   input wire logic [1:0]  o_in_chan,
   input wire logic        o_out_drive,
   input wire logic [2:0]  o_out_chan,
   input wire logic [8:0]  o_dac,
   input wire logic        o_alu_enable,
   input wire logic        o_cond_bit,
   input wire logic        o_cond_active,
   input wire logic        o_alu_nop,
   input wire logic        o_clear_carry,
   input wire logic [24:0] o_conv_word,
   input wire logic        o_res_valid,
   input wire logic        o_res_room
);
   // ----------------------------------------------------------------
   // one domain, so clock and reset are given once
   // ----------------------------------------------------------------
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   property p_in; o_in_sample == (i_acode[5:2] == 4'h1) && (!o_in_sample || o_in_chan == i_acode[1:0]); endproperty
   a_in: assert property (p_in) else $error("input sample decode wrong");
   property p_out; o_out_drive == (i_acode[5:3] == 3'h1) && (!o_out_drive || (o_out_chan == i_acode[2:0] && o_dac == o_conv_word[24:16])); endproperty
   a_out: assert property (p_out) else $error("output drive decode wrong");
   property p_nop; o_alu_nop == (i_opcode == 3'h2 && i_dst == 6'h00 && i_src == 6'h00 && i_shift == 4'hF) && o_clear_carry == o_alu_nop; endproperty
   a_nop: assert property (p_nop) else $error("alu no-op decode wrong");
   property p_ena; o_alu_enable == !(o_cond_active && !o_cond_bit && (i_opcode == 3'h0 || i_opcode == 3'h2)); endproperty
   a_ena: assert property (p_ena) else $error("alu enable gating wrong");
   property p_sel; o_cond_active == (i_acode >= 6'h20 && i_acode <= 6'h28) && (!o_cond_active || o_cond_bit == o_conv_word[16 + i_acode[3:0]]); endproperty
   a_sel: assert property (p_sel) else $error("conditional bit wrong");
   property p_low; o_conv_word[15:0] == 16'hFFFF; endproperty
   a_low: assert property (p_low) else $error("low word bits not ones");
   property p_dac; o_dac == (o_conv_word[24:16] | ((i_acode[5:3] == 3'h2) ? (9'h001 << i_acode[2:0]) : 9'h000)); endproperty
   a_dac: assert property (p_dac) else $error("converter input wrong");
   property p_sgn; i_acode == 6'h18 |=> o_conv_word[24] == !$past(i_cmp_high); endproperty
   a_sgn: assert property (p_sgn) else $error("sign step result wrong");
   property p_mag; i_acode[5:3] == 3'h2 |=> o_conv_word[16 + $past(i_acode[2:0])] == $past(i_cmp_high); endproperty
   a_mag: assert property (p_mag) else $error("magnitude step result wrong");
   property p_wrap; o_pc == 8'hBF |=> o_pc == 8'h00; endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");
   property p_eop; i_acode == 6'h01 |=> o_pc == $past(o_pc) + 8'h01 ##2 o_pc == $past(o_pc, 3) + 8'h03 ##1 o_pc == 8'h00; endproperty
   a_eop: assert property (p_eop) else $error("end code timing wrong");
   property p_res; i_acode == 6'h10 && o_res_room |-> ##2 o_res_valid; endproperty
   a_res: assert property (p_res) else $error("result not queued");
   c_eop: cover property (i_acode == 6'h01);
   c_res: cover property (o_res_valid && !o_res_room);
   c_cancel: cover property (o_cond_active && !o_alu_enable);
   c_wrap: cover property (o_pc == 8'hBF);
endmodule : aic_ctrl_chk

bind aic_ctrl aic_ctrl_chk i_aic_ctrl_chk (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_acode(i_acode), .i_opcode(i_opcode), .i_shift(i_shift),
   .i_dst(i_dst), .i_src(i_src), .i_cmp_high(i_cmp_high), .o_pc(o_pc), .o_in_sample(o_in_sample),
   .o_in_chan(o_in_chan), .o_out_drive(o_out_drive), .o_out_chan(o_out_chan), .o_dac(o_dac),
   .o_alu_enable(o_alu_enable), .o_cond_bit(o_cond_bit), .o_cond_active(o_cond_active),
   .o_alu_nop(o_alu_nop), .o_clear_carry(o_clear_carry), .o_conv_word(o_conv_word),
   .o_res_valid(o_res_valid), .o_res_room(o_res_room)
);

//--- aic_afe_model.sv
/*
 * behavioural analog front end: four input levels, sample-and-hold and
 * a comparator against the converter input.
 * assumes levels are two's complement codes on the converter's scale.
 */
`timescale 1ns/1ps
module aic_afe_model (
   input  wire logic            i_mclk,
   input  wire logic [3:0][8:0] i_lvl,
   input  wire logic            i_in_sample,
   input  wire logic [1:0]      i_in_chan,
   input  wire logic [8:0]      i_dac,
   output logic                 o_cmp_high
);
   logic [8:0] held = 9'h000;  // hold capacitor, kept between samples
   always @(posedge i_mclk) begin
      if (i_in_sample === 1'b1) begin
         held <= i_lvl[i_in_chan];
      end
   end
   assign o_cmp_high = $signed(held) > $signed(i_dac);
endmodule : aic_afe_model

//--- tb_aic_ctrl.sv
/*
 * testbench for the analog control decoder: one word per clock, checks
 * of channel, alu, conversion, queue and program counter behaviour.
 * assumes the front-end model aic_afe_model on the comparator input.
 */
`timescale 1ns/1ps
module tb_aic_ctrl;
   logic            mclk = 1'b0;
   logic            rst = 1'b1;
   logic [5:0]      acode = 6'h00;
   logic [2:0]      opcode = 3'h2;
   logic [3:0]      shift = 4'hF;
   logic [5:0]      dst = 6'h00;
   logic [5:0]      src = 6'h00;
   logic            wr = 1'b0;
   logic [8:0]      wd = 9'h000;
   logic            rdy = 1'b1;
   logic [3:0][8:0] lvl = '0;
   logic            cmp, ins, outd, ena, cbit, cact, nop, clc, rv, room;
   logic [1:0]      inch;
   logic [2:0]      outch;
   logic [7:0]      pc;
   logic [8:0]      dac, rd;
   logic [24:0]     cw;
   logic [8:0]      q[$];  // expected results in queue order
   int              err_count = 0;
   int              checks_done = 0;

   aic_ctrl i_aic_ctrl (
      .i_mclk(mclk), .i_rst(rst), .i_acode(acode), .i_opcode(opcode), .i_shift(shift),
      .i_dst(dst), .i_src(src), .i_conv_wr(wr), .i_conv_data(wd), .i_cmp_high(cmp),
      .o_pc(pc), .o_in_sample(ins), .o_in_chan(inch), .o_out_drive(outd), .o_out_chan(outch),
      .o_dac(dac), .o_alu_enable(ena), .o_cond_bit(cbit), .o_cond_active(cact),
      .o_alu_nop(nop), .o_clear_carry(clc), .o_conv_word(cw), .o_res_valid(rv),
      .i_res_ready(rdy), .o_res_data(rd), .o_res_room(room));
   aic_afe_model i_aic_afe_model (.i_mclk(mclk), .i_lvl(lvl), .i_in_sample(ins),
      .i_in_chan(inch), .i_dac(dac), .o_cmp_high(cmp));

   initial begin
      forever #2.5 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic final_report();
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task automatic chk_b(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t flag got %b exp %b", $time, g, e);
      end
   endtask : chk_b
   task automatic chk_v(input logic [24:0] g, input logic [24:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t value got %h exp %h", $time, g, e);
      end
   endtask : chk_v
   // greedy approximation as the comparator decides it
   function automatic logic [8:0] exp_conv(input logic [8:0] s);
      logic [8:0] r;
      r = ($signed(s) > 0) ? 9'h000 : 9'h100;
      for (int b = 7; b >= 0; b--) begin
         if ($signed(s) > $signed(r | (9'h001 << b))) r = r | (9'h001 << b);
      end
      return r;
   endfunction : exp_conv
   // one instruction word, changed just after the edge
   task automatic word(input logic [5:0] ac, input logic [2:0] op = 3'h2,
                       input logic [5:0] ds = 6'h00, input logic w = 1'b0,
                       input logic [8:0] d = 9'h000, input logic [5:0] sr = 6'h00,
                       input logic [3:0] sh = 4'hF);
      @(posedge mclk);
      acode <= ac;
      opcode <= op;
      dst <= ds;
      src <= sr;
      shift <= sh;
      wr <= w;
      wd <= d;
      #1;
   endtask : word
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_io();
      for (int c = 0; c < 4; c++) begin
         word({4'h1, 2'(c)});
         chk_b(ins, 1'b1);
         chk_v(25'(inch), 25'(c));
         chk_b(nop, 1'b1);
      end
      for (int c = 0; c < 8; c++) begin
         word({3'h1, 3'(c)});
         chk_b(outd & ~ins, 1'b1);
         chk_v(25'({outch, dac}), 25'({3'(c), cw[24:16]}));
      end
   endtask : t_io
   task automatic t_nop();
      word(6'h00);
      chk_b(nop & clc, 1'b1);
      word(6'h00, 3'h0);
      chk_b(nop | clc, 1'b0);
      word(6'h00, 3'h2, 6'h01);
      chk_b(nop, 1'b0);
      word(6'h00, 3'h2, 6'h00, 1'b0, 9'h000, 6'h01);
      chk_b(nop, 1'b0);
      word(6'h00, 3'h2, 6'h00, 1'b0, 9'h000, 6'h00, 4'hE);
      chk_b(clc, 1'b0);
   endtask : t_nop
   task automatic t_conv(input logic [8:0] s, input logic [1:0] c);
      lvl[c] <= s;
      word({4'h1, c});
      word(6'h00, 3'h2, 6'h3F, 1'b1, 9'h000);
      for (int b = 8; b >= 0; b--) begin
         word(6'h10 + 6'(b), 3'h0, 6'h05);
         if (b > 0) word(6'h00);
      end
      word(6'h00);
      q.push_back(exp_conv(s));
      chk_v(cw, {q[$], 16'hFFFF});
   endtask : t_conv
   task automatic t_pop();
      for (int n = 0; n < 8 && rv !== 1'b1; n++) word(6'h00);
      chk_v(25'(rd), 25'(q.pop_front()));
      word(6'h00);
   endtask : t_pop
   task automatic t_cond();
      logic [8:0] v;
      v = 9'h15A;
      word(6'h00, 3'h2, 6'h3F, 1'b1, v);
      for (int b = 0; b < 9; b++) begin
         for (int k = 0; k < 3; k++) begin
            word(6'h20 + 6'(b), 3'(k));
            chk_b(cbit & cact, v[b]);
            chk_b(ena, v[b] | (k == 1));
         end
      end
   endtask : t_cond
   task automatic t_fifo();
      @(posedge mclk);
      rdy <= 1'b0;
      for (int i = 0; i < 5; i++) t_conv(9'h040 + 9'(i * 23), 2'(i));
      void'(q.pop_back());
      word(6'h00);
      word(6'h00);
      chk_b(room | ~rv, 1'b0);
      @(posedge mclk);
      rdy <= 1'b1;
      #1;
      for (int i = 0; i < 4; i++) t_pop();
      chk_b(rv, 1'b0);
   endtask : t_fifo
   task automatic t_flow();
      for (int n = 0; n < 200 && pc !== 8'hBF; n++) word(6'h00);
      word(6'h00);
      chk_v(25'(pc), 25'h0);
      for (int n = 0; n < 200 && pc !== 8'h07; n++) word(6'h00);
      word(6'h01);
      for (int i = 9; i < 12; i++) begin
         word(6'h00);
         chk_v(25'(pc), 25'(i));
      end
      word(6'h00);
      chk_v(25'(pc), 25'h0);
   endtask : t_flow

   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk_v({pc, 6'h00, rv, room, cw[24:16]}, 25'h0200);
      t_io();
      t_nop();
      t_conv(9'h05A, 2'h1);
      t_pop();
      t_conv(9'h1A3, 2'h2);
      t_pop();
      t_conv(9'h000, 2'h3);
      t_pop();
      t_cond();
      t_fifo();
      t_flow();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      final_report();
   end
endmodule : tb_aic_ctrl
